// ===== design/regs_pkg.sv
// Package: register map, field layout and reset values of the core register set
package regs_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 24;
  localparam int HALF_W = 16;

  // ********************************************************************
  // Register byte addresses on the bus
  // ********************************************************************
  localparam logic [7:0] GPR_BASE_OFF   = 8'h00;  // Eight words, 0x00..0x1C
  localparam logic [7:0] PC_OFF         = 8'h20;
  localparam logic [7:0] ISP_OFF        = 8'h24;
  localparam logic [7:0] USP_OFF        = 8'h28;
  localparam logic [7:0] FP_OFF         = 8'h2C;
  localparam logic [7:0] SB_OFF         = 8'h30;
  localparam logic [7:0] DTB_OFF        = 8'h34;
  localparam logic [7:0] UDP_OFF        = 8'h38;
  localparam logic [7:0] PSW_OFF        = 8'h3C;
  localparam logic [7:0] SP_SEL_OFF     = 8'h40;  // Currently selected stack pointer, read only

  // ********************************************************************
  // Status word fields
  // ********************************************************************
  localparam int PSW_S_BIT = 9;
  localparam int PSW_U_BIT = 8;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [15:0] PSW_RST = 16'h0000;

  // ********************************************************************
  // Operand sizes, stack operations and bus response codes
  // ********************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DBL  = 2'h3;

  localparam logic [1:0] STK_NONE = 2'h0;
  localparam logic [1:0] STK_PUSH = 2'h1;
  localparam logic [1:0] STK_POP  = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== design/core_registers.sv
// Module: core register set with operand port, stack engine and register bus
// Contract
// - Eight 32-bit general registers, usable as data or address.
// - Byte and word operand writes change only the low bits of a register.
// - Program counter holds the address of the executing instruction's first byte.
// - Top eight bits of all pointers except unit pointer read as zero.
// - Stack select bit 0 picks interrupt stack, 1 picks user stack.
// - Each stack pointer addresses the lowest byte of its latest item.
// - Push decrements the selected pointer by operand length, then stores.
// - Pop reads at the selected pointer, then increments by operand length.
// - Frame pointer loaded on procedure entry, restored on procedure exit.
// - Static base holds lowest address of the module's global area.
// - Dispatch table base holds lowest address of the dispatch table.
// - Unit descriptor pointer is sixteen bits wide.
// - Status word low half open to all, high half supervisor only.
// - Address pointers are 24 bits wide.
// - Stack select bit clears whenever an interrupt or trap is taken.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps

module core_registers (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // General register operand port
  input  wire logic        gpr_we,
  input  wire logic [2:0]  gpr_waddr,
  input  wire logic [1:0]  gpr_wsize,
  input  wire logic [31:0] gpr_wdata,
  input  wire logic [2:0]  gpr_raddr,
  input  wire logic [1:0]  gpr_rsize,
  output logic      [31:0] gpr_rdata,
  // Dedicated register updates from execution
  input  wire logic        pc_we,
  input  wire logic [31:0] pc_wdata,
  input  wire logic        fp_we,
  input  wire logic [31:0] fp_wdata,
  input  wire logic        sb_we,
  input  wire logic [31:0] sb_wdata,
  input  wire logic        dtb_we,
  input  wire logic [31:0] dtb_wdata,
  input  wire logic        udp_we,
  input  wire logic [15:0] udp_wdata,
  input  wire logic        psw_we,
  input  wire logic [15:0] psw_wdata,
  input  wire logic        trap_taken,
  // Stack engine
  input  wire logic [1:0]  stk_op,
  input  wire logic [1:0]  stk_size,
  output logic      [31:0] stk_addr,
  // Register views
  output logic      [31:0] program_counter,
  output logic      [31:0] frame_pointer,
  output logic      [31:0] static_base,
  output logic      [31:0] dispatch_table_base,
  output logic      [15:0] unit_descriptor_ptr,
  output logic      [15:0] processor_status_word,
  output logic             supervisor,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ********************************************************************
  // Helpers
  // ********************************************************************

  // Merge operand into a register, keeping bits above the operand size
  function automatic logic [31:0] merge_size(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [1:0] size);
    unique case (size)
      regs_pkg::SIZE_BYTE: merge_size = {old_v[31:8], new_v[7:0]};
      regs_pkg::SIZE_WORD: merge_size = {old_v[31:16], new_v[15:0]};
      default:             merge_size = new_v;
    endcase
  endfunction

  // Pointer clamp: only 24 address bits exist
  function automatic logic [31:0] ptr24(input logic [31:0] v);
    ptr24 = {8'h00, v[regs_pkg::ADDR_W-1:0]};
  endfunction

  // Merge bus data by byte strobe
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      strb_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

  // ********************************************************************
  // Storage
  // ********************************************************************
  logic [31:0] gpr_q [8];
  logic [23:0] pc_q;
  logic [23:0] isp_q;
  logic [23:0] usp_q;
  logic [23:0] fp_q;
  logic [23:0] sb_q;
  logic [23:0] dtb_q;
  logic [15:0] udp_q;
  logic [15:0] psw_q;

  // Bus write and read paths
  logic        aw_hold_q;
  logic [7:0]  aw_addr_q;
  logic        w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bus_wr;
  logic        bus_wr_ok;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // ********************************************************************
  // Stack engine
  // ********************************************************************
  logic        use_user_stack;
  logic [23:0] sp_cur;
  logic [23:0] stk_len;
  logic [23:0] sp_next;

  // Stack select from status word
  assign use_user_stack = psw_q[regs_pkg::PSW_S_BIT];
  assign sp_cur         = use_user_stack ? usp_q : isp_q;
  assign stk_len        = (stk_size == regs_pkg::SIZE_BYTE) ? 24'h000001  // Size 2 counts as a double word
                        : ((stk_size == regs_pkg::SIZE_WORD) ? 24'h000002 : 24'h000004);

  // Push pre-decrements, pop post-increments; stacks grow downward
  always_comb begin
    sp_next  = sp_cur;
    stk_addr = ptr24({8'h00, sp_cur});
    if (stk_op == regs_pkg::STK_PUSH) begin
      sp_next  = sp_cur - stk_len;
      stk_addr = {8'h00, sp_next};
    end else if (stk_op == regs_pkg::STK_POP) begin
      sp_next = sp_cur + stk_len;
    end
  end

  assign supervisor = ~psw_q[regs_pkg::PSW_U_BIT];

  // ********************************************************************
  // Bus write acceptance
  // ********************************************************************
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign bus_wr        = aw_hold_q & w_hold_q & ~bvalid_q;
  assign bus_wr_ok     = bus_wr && aw_addr_q <= regs_pkg::PSW_OFF;

  // Address and data taken in either order
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end else if (bus_wr) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (bus_wr) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= regs_pkg::RESP_OKAY;
    end else if (bus_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= bus_wr_ok ? regs_pkg::RESP_OKAY : regs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ********************************************************************
  // General registers: bus write wins over operand port on a clash
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        gpr_q[i] <= regs_pkg::PTR_RST;
      end
    end else if (bus_wr_ok && aw_addr_q < regs_pkg::PC_OFF) begin
      gpr_q[aw_addr_q[4:2]] <= strb_merge(gpr_q[aw_addr_q[4:2]], w_data_q, w_strb_q);
    end else if (gpr_we) begin
      gpr_q[gpr_waddr] <= merge_size(gpr_q[gpr_waddr], gpr_wdata, gpr_wsize);
    end
  end

  // Operand read returns only the low part for narrow operands
  always_comb begin
    unique case (gpr_rsize)
      regs_pkg::SIZE_BYTE: gpr_rdata = {24'h0, gpr_q[gpr_raddr][7:0]};
      regs_pkg::SIZE_WORD: gpr_rdata = {16'h0, gpr_q[gpr_raddr][15:0]};
      default:             gpr_rdata = gpr_q[gpr_raddr];
    endcase
  end

  // ********************************************************************
  // Dedicated pointers; only 24 bits (16 for the unit pointer) are stored so upper bits read zero
  // ********************************************************************

  // Bus word merged into a 24-bit pointer; the top byte has no storage
  function automatic logic [23:0] ptr_merge(input logic [23:0] old_v);
    ptr_merge = 24'(strb_merge({8'h00, old_v}, w_data_q, w_strb_q));
  endfunction

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pc_q  <= regs_pkg::PTR_RST[23:0];
      fp_q  <= regs_pkg::PTR_RST[23:0];
      sb_q  <= regs_pkg::PTR_RST[23:0];
      dtb_q <= regs_pkg::PTR_RST[23:0];
      udp_q <= regs_pkg::PTR_RST[15:0];
    end else begin
      // Instruction address of the executing instruction
      if (pc_we) pc_q <= pc_wdata[23:0];
      else if (bus_wr_ok && aw_addr_q == regs_pkg::PC_OFF) pc_q <= ptr_merge(pc_q);
      // Frame pointer from procedure entry and exit
      if (fp_we) fp_q <= fp_wdata[23:0];
      else if (bus_wr_ok && aw_addr_q == regs_pkg::FP_OFF) fp_q <= ptr_merge(fp_q);
      if (sb_we) sb_q <= sb_wdata[23:0];
      else if (bus_wr_ok && aw_addr_q == regs_pkg::SB_OFF) sb_q <= ptr_merge(sb_q);
      if (dtb_we) dtb_q <= dtb_wdata[23:0];
      else if (bus_wr_ok && aw_addr_q == regs_pkg::DTB_OFF) dtb_q <= ptr_merge(dtb_q);
      if (udp_we) udp_q <= udp_wdata;
      else if (bus_wr_ok && aw_addr_q == regs_pkg::UDP_OFF) udp_q <= 16'(ptr_merge({8'h00, udp_q}));
    end
  end

  // Stack pointers: stack engine first, then bus
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      isp_q <= regs_pkg::PTR_RST[23:0];
      usp_q <= regs_pkg::PTR_RST[23:0];
    end else begin
      if (stk_op != regs_pkg::STK_NONE && !use_user_stack) isp_q <= sp_next;
      else if (bus_wr_ok && aw_addr_q == regs_pkg::ISP_OFF) isp_q <= ptr_merge(isp_q);
      if (stk_op != regs_pkg::STK_NONE && use_user_stack) usp_q <= sp_next;
      else if (bus_wr_ok && aw_addr_q == regs_pkg::USP_OFF) usp_q <= ptr_merge(usp_q);
    end
  end

  // ********************************************************************
  // Status word: high half writable only in supervisor mode
  // ********************************************************************
  logic [15:0] psw_src;
  logic [1:0]  psw_lanes;
  logic        psw_wr;

  always_comb begin
    psw_wr    = psw_we;
    psw_src   = psw_wdata;
    psw_lanes = 2'b11;
    if (!psw_we && bus_wr_ok && aw_addr_q == regs_pkg::PSW_OFF) begin
      psw_wr    = 1'b1;
      psw_src   = w_data_q[15:0];
      psw_lanes = w_strb_q[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      psw_q <= regs_pkg::PSW_RST;
    end else begin
      if (psw_wr && psw_lanes[0]) psw_q[7:0] <= psw_src[7:0];
      if (trap_taken) begin
        psw_q[regs_pkg::PSW_S_BIT] <= 1'b0;
      end else if (psw_wr && psw_lanes[1] && supervisor) begin
        psw_q[15:8] <= psw_src[15:8];
      end
    end
  end

  // ********************************************************************
  // Bus reads
  // ********************************************************************
  function automatic logic [31:0] read_reg(input logic [7:0] a);
    if (a < regs_pkg::PC_OFF) read_reg = gpr_q[a[4:2]];
    else begin
      unique case (a)
        regs_pkg::PC_OFF:     read_reg = {8'h00, pc_q};
        regs_pkg::ISP_OFF:    read_reg = {8'h00, isp_q};
        regs_pkg::USP_OFF:    read_reg = {8'h00, usp_q};
        regs_pkg::FP_OFF:     read_reg = {8'h00, fp_q};
        regs_pkg::SB_OFF:     read_reg = {8'h00, sb_q};
        regs_pkg::DTB_OFF:    read_reg = {8'h00, dtb_q};
        regs_pkg::UDP_OFF:    read_reg = {16'h0, udp_q};
        regs_pkg::PSW_OFF:    read_reg = {16'h0, psw_q};
        regs_pkg::SP_SEL_OFF: read_reg = {8'h00, sp_cur};
        default:              read_reg = 32'h0000_0000;
      endcase
    end
  endfunction

  assign s_axi_arready = ~rvalid_q;

  // One read at a time; data registered one cycle after acceptance
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= regs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= read_reg({s_axi_araddr[7:2], 2'b00});
      rresp_q  <= ({s_axi_araddr[7:2], 2'b00} <= regs_pkg::SP_SEL_OFF) ? regs_pkg::RESP_OKAY
                                                                       : regs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ********************************************************************
  // Register views
  // ********************************************************************
  assign program_counter       = {8'h00, pc_q};
  assign frame_pointer         = {8'h00, fp_q};
  assign static_base           = {8'h00, sb_q};
  assign dispatch_table_base   = {8'h00, dtb_q};
  assign unit_descriptor_ptr   = udp_q;
  assign processor_status_word = psw_q;

endmodule // core_registers

// ===== dv/core_registers_checker.sv
// Checker: assertions on the core register set ports
`timescale 1ns/1ps
module core_registers_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Core side
  input wire logic        gpr_we,
  input wire logic [2:0]  gpr_waddr,
  input wire logic [1:0]  gpr_wsize,
  input wire logic [31:0] gpr_wdata,
  input wire logic [2:0]  gpr_raddr,
  input wire logic [1:0]  gpr_rsize,
  input wire logic [31:0] gpr_rdata,
  input wire logic        pc_we,
  input wire logic [31:0] pc_wdata,
  input wire logic        fp_we,
  input wire logic [31:0] fp_wdata,
  input wire logic        udp_we,
  input wire logic [15:0] udp_wdata,
  input wire logic        psw_we,
  input wire logic [15:0] psw_wdata,
  input wire logic        trap_taken,
  input wire logic [1:0]  stk_op,
  input wire logic [1:0]  stk_size,
  input wire logic [31:0] stk_addr,
  // Views
  input wire logic [31:0] program_counter,
  input wire logic [31:0] frame_pointer,
  input wire logic [31:0] static_base,
  input wire logic [31:0] dispatch_table_base,
  input wire logic [15:0] unit_descriptor_ptr,
  input wire logic [15:0] processor_status_word,
  input wire logic        supervisor,
  input wire logic        s_axi_bvalid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Operand length in bytes; size 2 counts as a double word
  function automatic logic [23:0] len_of(input logic [1:0] s);
    return (s == regs_pkg::SIZE_BYTE) ? 24'h1 : ((s == regs_pkg::SIZE_WORD) ? 24'h2 : 24'h4);
  endfunction

  // Stack steps; a bus write landing on the same edge could move the pointer, so it is left out
  sequence push_s;
    stk_op == regs_pkg::STK_PUSH && !trap_taken && !psw_we;
  endsequence
  sequence pop_s;
    stk_op == regs_pkg::STK_POP && !trap_taken && !psw_we;
  endsequence
  sequence idle_s;
    stk_op == regs_pkg::STK_NONE && !$rose(s_axi_bvalid);
  endsequence
  sequence narrow_s;
    gpr_we && gpr_wsize == regs_pkg::SIZE_BYTE && gpr_raddr == gpr_waddr && gpr_rsize == regs_pkg::SIZE_DBL
    ##1 gpr_raddr == $past(gpr_raddr) && gpr_rsize == regs_pkg::SIZE_DBL && !$rose(s_axi_bvalid);
  endsequence

  ptr_top_zero_a: assert property (
    (program_counter | frame_pointer | static_base | dispatch_table_base) < 32'h0100_0000)
    else $error("pointer top byte not zero");
  push_pointer_a: assert property (push_s ##1 idle_s |-> stk_addr[23:0] == $past(stk_addr[23:0]))
    else $error("push left wrong pointer");
  pop_pointer_a: assert property (pop_s ##1 idle_s |->
    stk_addr[23:0] == $past(stk_addr[23:0]) + len_of($past(stk_size)))
    else $error("pop left wrong pointer");
  pc_load_a: assert property (pc_we |=> program_counter == {8'h00, $past(pc_wdata[23:0])})
    else $error("program counter load wrong");
  fp_load_a: assert property (fp_we |=> frame_pointer == {8'h00, $past(fp_wdata[23:0])})
    else $error("frame pointer load wrong");
  udp_load_a: assert property (udp_we |=> unit_descriptor_ptr == $past(udp_wdata))
    else $error("unit pointer load wrong");
  trap_clear_a: assert property (trap_taken |=> !processor_status_word[regs_pkg::PSW_S_BIT])
    else $error("stack select not cleared");
  psw_super_a: assert property (psw_we && supervisor && !trap_taken |=>
    processor_status_word == $past(psw_wdata))
    else $error("status write lost in supervisor mode");
  psw_user_a: assert property (psw_we && !supervisor && !trap_taken |=>
    processor_status_word == {$past(processor_status_word[15:8]), $past(psw_wdata[7:0])})
    else $error("status high half changed in user mode");
  gpr_narrow_a: assert property (narrow_s |-> gpr_rdata == {$past(gpr_rdata[31:8]), $past(gpr_wdata[7:0])})
    else $error("byte write touched high bits");
endmodule // core_registers_checker

bind core_registers core_registers_checker chk_u (.*);

// ===== dv/core_registers_tb.sv
// Testbench: self-checking bench for the core register set
`timescale 1ns/1ps
module core_registers_tb;
  // ********************************************************************
  // Signals
  // ********************************************************************
  logic        clock = '0, rst_n = '0, gpr_we = '0, pc_we = '0, fp_we = '0, sb_we = '0, dtb_we = '0;
  logic        udp_we = '0, psw_we = '0, trap_taken = '0, supervisor;
  logic [2:0]  gpr_waddr = '0, gpr_raddr = '0;
  logic [1:0]  gpr_wsize = '0, gpr_rsize = '0, stk_op = '0, stk_size = '0, s_axi_bresp, s_axi_rresp;
  logic [31:0] gpr_wdata = '0, pc_wdata = '0, fp_wdata = '0, sb_wdata = '0, dtb_wdata = '0, s_axi_wdata = '0;
  logic [15:0] udp_wdata = '0, psw_wdata = '0, unit_descriptor_ptr, processor_status_word;
  logic [31:0] gpr_rdata, stk_addr, program_counter, frame_pointer, static_base, dispatch_table_base, s_axi_rdata;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        aw_ok, w_ok, b_ok, ar_ok, r_ok;
  int          errors = 0, num_checks = 0, cycles = 0;
  logic [1:0]  exp_b[$];
  logic [33:0] exp_r[$];
  logic [31:0] x, w;
  logic [23:0] p;

  core_registers dut_u (.*);

  // Clock and hang guard; the run needs a few hundred cycles
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_port(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_resp(input string name, input logic [33:0] exp, input logic [33:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Handshakes are judged at the falling edge, where they are settled for the next rising edge
  task automatic tick();
    @(negedge clock);
    aw_ok = s_axi_awvalid && s_axi_awready;
    w_ok = s_axi_wvalid && s_axi_wready;
    b_ok = s_axi_bvalid;
    ar_ok = s_axi_arready;
    r_ok = s_axi_rvalid;
    @(posedge clock);
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic da, dw;
    da = 1'h0;
    dw = 1'h0;
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(da && dw)) begin
      tick();
      if (aw_ok) s_axi_awvalid <= 1'h0;
      if (w_ok) s_axi_wvalid <= 1'h0;
      da = da | aw_ok;
      dw = dw | w_ok;
    end
    do tick(); while (!b_ok);
    s_axi_bready <= 1'h0;
    @(posedge clock);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do tick(); while (!ar_ok);
    s_axi_arvalid <= 1'h0;
    do tick(); while (!r_ok);
    s_axi_rready <= 1'h0;
    @(posedge clock);
  endtask

  // Response watcher: oldest note against each answer
  always @(negedge clock) begin
    if (rst_n && s_axi_rvalid && s_axi_rready)
      cmp_resp("read", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (rst_n && s_axi_bvalid && s_axi_bready)
      cmp_resp("bresp", {32'h0, exp_b.pop_front()}, {32'h0, s_axi_bresp});
  end

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin
    void'($urandom(69591));
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
    for (int i = 0; i < 17; i++) axi_read(8'(i * 4), 32'h0, regs_pkg::RESP_OKAY);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      x = $urandom();
      axi_write(8'(i * 4), x, 4'hF, regs_pkg::RESP_OKAY);
      axi_read(8'(i * 4), x, regs_pkg::RESP_OKAY);
    end
    axi_write(8'h1C, 32'hA5A5A5A5, 4'h2, regs_pkg::RESP_OKAY);
    axi_read(8'h1C, {x[31:16], 8'hA5, x[7:0]}, regs_pkg::RESP_OKAY);
    $display("test general registers done");
    // Byte then word operand writes back to back, full view read alongside
    x = $urandom();
    w = $urandom();
    axi_write(8'h0C, x, 4'hF, regs_pkg::RESP_OKAY);
    {gpr_we, gpr_waddr, gpr_wsize, gpr_wdata} <= {1'h1, 3'h3, regs_pkg::SIZE_BYTE, w};
    {gpr_raddr, gpr_rsize} <= {3'h3, regs_pkg::SIZE_DBL};
    @(posedge clock);
    gpr_wsize <= regs_pkg::SIZE_WORD;
    @(posedge clock);
    gpr_we <= 1'h0;
    gpr_rsize <= regs_pkg::SIZE_BYTE;
    @(negedge clock);
    cmp_port("gpr_rdata", {24'h0, w[7:0]}, gpr_rdata);
    @(posedge clock);
    axi_read(8'h0C, {x[31:16], w[15:0]}, regs_pkg::RESP_OKAY);
    $display("test narrow operands done");
    // Core loads of the dedicated pointers, all in one cycle
    x = $urandom();
    {pc_we, fp_we, sb_we, dtb_we, udp_we} <= 5'h1F;
    {pc_wdata, fp_wdata, sb_wdata, dtb_wdata} <= {4{x}};
    udp_wdata <= x[15:0];
    @(posedge clock);
    {pc_we, fp_we, sb_we, dtb_we, udp_we} <= 5'h00;
    @(negedge clock);
    cmp_port("program_counter", {8'h00, x[23:0]}, program_counter);
    cmp_port("frame_pointer", {8'h00, x[23:0]}, frame_pointer);
    cmp_port("static_base", {8'h00, x[23:0]}, static_base);
    cmp_port("dispatch_table_base", {8'h00, x[23:0]}, dispatch_table_base);
    cmp_port("unit_descriptor_ptr", {16'h0, x[15:0]}, {16'h0, unit_descriptor_ptr});
    @(posedge clock);
    for (int i = 8; i < 15; i++) begin
      axi_write(8'(i * 4), 32'hFFFFFFFF, 4'hF, regs_pkg::RESP_OKAY);
      axi_read(8'(i * 4), (i == 14) ? 32'h0000FFFF : 32'h00FFFFFF, regs_pkg::RESP_OKAY);
    end
    $display("test pointers done");
    // Push, idle, pop for every operand size on the interrupt stack
    p = 24'h100000 + 24'($urandom() & 32'hFFFC);
    axi_write(regs_pkg::ISP_OFF, {8'h00, p}, 4'hF, regs_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      stk_size <= 2'(i); // Size 2 counts as a double word
      stk_op <= regs_pkg::STK_PUSH;
      w = (i < 2) ? 32'(1 << i) : 32'h4;
      p = p - w[23:0];
      @(negedge clock);
      cmp_port("push stk_addr", {8'h00, p}, stk_addr);
      @(posedge clock);
      stk_op <= regs_pkg::STK_NONE;
      axi_read(regs_pkg::ISP_OFF, {8'h00, p}, regs_pkg::RESP_OKAY);
      stk_op <= regs_pkg::STK_POP;
      @(negedge clock);
      cmp_port("pop stk_addr", {8'h00, p}, stk_addr);
      @(posedge clock);
      stk_op <= regs_pkg::STK_NONE;
      p = p + w[23:0];
      axi_read(regs_pkg::SP_SEL_OFF, {8'h00, p}, regs_pkg::RESP_OKAY);
    end
    axi_write(regs_pkg::PSW_OFF, 32'h00000200, 4'hF, regs_pkg::RESP_OKAY);
    axi_read(regs_pkg::SP_SEL_OFF, 32'h00FFFFFF, regs_pkg::RESP_OKAY);
    trap_taken <= 1'h1;
    @(posedge clock);
    trap_taken <= 1'h0;
    axi_read(regs_pkg::SP_SEL_OFF, {8'h00, p}, regs_pkg::RESP_OKAY);
    $display("test stacks done");
    // Enter user mode, then try the high half from core and bus
    {psw_we, psw_wdata} <= {1'h1, 16'h01AA};
    @(posedge clock);
    psw_wdata <= 16'h0255;
    @(posedge clock);
    psw_we <= 1'h0;
    axi_read(regs_pkg::PSW_OFF, 32'h00000155, regs_pkg::RESP_OKAY);
    cmp_port("supervisor", 32'h0, {31'h0, supervisor});
    axi_write(regs_pkg::PSW_OFF, 32'h0000FE33, 4'hF, regs_pkg::RESP_OKAY);
    axi_read(regs_pkg::PSW_OFF, 32'h00000133, regs_pkg::RESP_OKAY);
    $display("test status word done");
    // Second reset, then unmapped places
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    axi_read(regs_pkg::PSW_OFF, 32'h0, regs_pkg::RESP_OKAY);
    x = 32'h44 + 4 * ($urandom() % 47);
    axi_write(x[7:0], 32'hFFFFFFFF, 4'hF, regs_pkg::RESP_SLVERR);
    axi_read(x[7:0], 32'h0, regs_pkg::RESP_SLVERR);
    $display("test reset and unmapped done");
    end_of_test();
  end
endmodule // core_registers_tb
